// ==== rtl/internal_error_status_mask.sv ====
// internal error status and report mask registers of one switch port
`timescale 1ns/1ns
`include "ierr_defines.svh"

module internal_error_status_mask
  import ierr_pkg::*;
#(
  parameter int ADDR_W = `IERR_ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ingress_data_double_err,
  input wire logic ingress_ctrl_single_err,
  input wire logic ingress_ctrl_double_err,
  input wire logic egress_data_single_err,
  input wire logic egress_data_double_err,
  input wire logic egress_ctrl_single_err,
  input wire logic egress_ctrl_double_err,
  input wire logic datapath_parity_err,
  input wire logic unreliable_link_flag,
  input wire logic replay_ctrl_single_err,
  input wire logic replay_ctrl_double_err,
  output logic [31:0] internal_error_report,
  output logic internal_error_pending
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == ADDR_W'(`IERR_STATUS_OFF)) begin
      sel = SEL_STATUS;
    end else if (addr == ADDR_W'(`IERR_MASK_OFF)) begin
      sel = SEL_MASK;
    end else if (addr == ADDR_W'(`IERR_REPORT_OFF)) begin
      sel = SEL_REPORT;
    end
    return sel;
  endfunction : decode

  // ----------------------------------------------------------------
  // constants and signals
  // ----------------------------------------------------------------

  localparam reg_word_t STATUS_IMPL = `IERR_STATUS_IMPL;
  localparam reg_word_t MASK_IMPL = `IERR_MASK_IMPL;
  localparam reg_word_t STATUS_RESET = `IERR_STATUS_RESET;
  localparam reg_word_t MASK_RESET = `IERR_MASK_RESET;
  localparam reg_word_t EDGE_BITS = `IERR_EDGE_BITS;
  localparam int LO_BIT = `IERR_LO_BIT;
  localparam int HI_BIT = `IERR_HI_BIT;

  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic status_wr;
  logic mask_wr;
  reg_word_t status_clr;
  reg_word_t status_q;
  reg_word_t status_d;
  reg_word_t mask_q;
  reg_word_t src_vec;
  reg_word_t event_vec;
  reg_word_t report_d;

  // ----------------------------------------------------------------
  // read view
  // ----------------------------------------------------------------

  function automatic reg_word_t read_view(
    input reg_sel_t which,
    input reg_word_t status,
    input reg_word_t mask,
    input reg_word_t report
  );
    reg_word_t word;
    word = '0;
    unique case (which)
      SEL_STATUS: begin
        word = status & STATUS_IMPL;
      end
      SEL_MASK: begin
        word = mask & MASK_IMPL;
      end
      SEL_REPORT: begin
        word = report;
      end
      SEL_NONE: begin
        word = '0;
      end
    endcase
    return word;
  endfunction : read_view

  // ----------------------------------------------------------------
  // strobe qualification
  // ----------------------------------------------------------------

  // one decode serves both strobes; an idle strobe selects nothing
  assign wr_sel = reg_wr ? decode(reg_addr) : SEL_NONE;
  assign rd_sel = reg_rd ? decode(reg_addr) : SEL_NONE;

  assign status_wr = (wr_sel == SEL_STATUS);
  assign mask_wr = (wr_sel == SEL_MASK);

  // ones written to reserved positions are dropped here
  assign status_clr = status_wr ? (reg_wdata & STATUS_IMPL) : '0;

  // ----------------------------------------------------------------
  // event collection
  // ----------------------------------------------------------------

  // raw sources placed at their status positions
  always_comb begin
    src_vec = '0;
    src_vec[`IERR_POS_IN_DATA_DBL] = ingress_data_double_err;
    src_vec[`IERR_POS_IN_CTRL_SGL] = ingress_ctrl_single_err;
    src_vec[`IERR_POS_IN_CTRL_DBL] = ingress_ctrl_double_err;
    src_vec[`IERR_POS_EG_DATA_SGL] = egress_data_single_err;
    src_vec[`IERR_POS_EG_DATA_DBL] = egress_data_double_err;
    src_vec[`IERR_POS_EG_CTRL_SGL] = egress_ctrl_single_err;
    src_vec[`IERR_POS_EG_CTRL_DBL] = egress_ctrl_double_err;
    src_vec[`IERR_POS_PARITY] = datapath_parity_err;
    src_vec[`IERR_POS_LINK] = unreliable_link_flag;
    src_vec[`IERR_POS_RP_CTRL_SGL] = replay_ctrl_single_err;
    src_vec[`IERR_POS_RP_CTRL_DBL] = replay_ctrl_double_err;
  end

  // level sources count every high cycle, edge sources only a rise
  for (genvar b = 0; b < 32; b++) begin : g_event
    if (EDGE_BITS[b]) begin : g_edge
      logic prev_q;

      // low after reset, so a flag already high counts as a rise
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          prev_q <= 1'b0;
        end else begin
          prev_q <= src_vec[b];
        end
      end

      assign event_vec[b] = src_vec[b] & ~prev_q;
    end else begin : g_level
      assign event_vec[b] = src_vec[b];
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------

  // one sticky flag per position; reserved positions stay zero
  for (genvar b = 0; b < 32; b++) begin : g_status
    if (b >= LO_BIT && b <= HI_BIT) begin : g_flag
      logic flag_q;
      logic flag_d;

      // a new event wins over a clear in the same cycle
      always_comb begin
        flag_d = flag_q;
        if (status_clr[b]) begin
          flag_d = 1'b0;
        end
        if (event_vec[b]) begin
          flag_d = 1'b1;
        end
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          flag_q <= STATUS_RESET[b];
        end else begin
          flag_q <= flag_d;
        end
      end

      assign status_q[b] = flag_q;
      assign status_d[b] = flag_d;
    end else begin : g_rsvd
      assign status_q[b] = 1'b0;
      assign status_d[b] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mask register
  // ----------------------------------------------------------------

  // storage for bits 0 to 18 except bit 3, including bits below the status flags
  for (genvar b = 0; b < 32; b++) begin : g_mask
    if (MASK_IMPL[b]) begin : g_bit
      logic bit_q;

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          bit_q <= MASK_RESET[b];
        end else if (mask_wr) begin
          bit_q <= reg_wdata[b];
        end
      end

      assign mask_q[b] = bit_q;
    end else begin : g_rsvd
      assign mask_q[b] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // reporting toward error capability
  // ----------------------------------------------------------------

  // next status, so the report rises together with the flag
  assign report_d = status_d & ~mask_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      internal_error_report <= 32'h0000_0000;
    end else begin
      internal_error_report <= report_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      internal_error_pending <= 1'b0;
    end else begin
      internal_error_pending <= |report_d;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------

  // idle cycles and unmapped addresses give zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= read_view(rd_sel, status_q, mask_q, internal_error_report);
    end
  end

endmodule : internal_error_status_mask

// ==== rtl/ierr_defines.svh ====
// register offsets, field positions and reset values of the error bank
`ifndef IERR_DEFINES_SVH
`define IERR_DEFINES_SVH

`define IERR_ADDR_W 12
`define IERR_STATUS_OFF 12'h484
`define IERR_MASK_OFF 12'h488
`define IERR_REPORT_OFF 12'h48C

`define IERR_STATUS_RESET 32'h0000_0000
`define IERR_MASK_RESET 32'h0000_0000

`define IERR_STATUS_IMPL 32'h0007_FF00
`define IERR_MASK_IMPL 32'h0007_FFF7

`define IERR_LO_BIT 8
`define IERR_HI_BIT 18

`define IERR_POS_IN_DATA_DBL 8
`define IERR_POS_IN_CTRL_SGL 9
`define IERR_POS_IN_CTRL_DBL 10
`define IERR_POS_EG_DATA_SGL 11
`define IERR_POS_EG_DATA_DBL 12
`define IERR_POS_EG_CTRL_SGL 13
`define IERR_POS_EG_CTRL_DBL 14
`define IERR_POS_PARITY 15
`define IERR_POS_LINK 16
`define IERR_POS_RP_CTRL_SGL 17
`define IERR_POS_RP_CTRL_DBL 18

`define IERR_EDGE_BITS 32'h0001_0000

`endif

// ==== rtl/ierr_pkg.sv ====
// types shared by the internal error status and mask bank
package ierr_pkg;

  typedef logic [31:0] reg_word_t;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_STATUS,
    SEL_MASK,
    SEL_REPORT
  } reg_sel_t;

endpackage : ierr_pkg

// ==== testbench/ierr_properties.sv ====
// port checks for the internal error status and mask bank
`timescale 1ns/1ns
module ierr_properties (
  input clk_sys,
  input rst_n,
  input [11:0] reg_addr,
  input [31:0] reg_wdata,
  input reg_wr,
  input reg_rd,
  input [31:0] reg_rdata,
  input ingress_data_double_err,
  input unreliable_link_flag,
  input [31:0] internal_error_report,
  input internal_error_pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // shadow of the last mask write
  logic [31:0] m_q;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      m_q <= '0;
    else if (reg_wr && reg_addr == 12'h488)
      m_q <= reg_wdata;
  a_pend_or: assert property (
    internal_error_pending == |internal_error_report) else $error("pend");
  a_data_dbl: assert property (ingress_data_double_err
    && !reg_wr && !m_q[8] |=> internal_error_report[8]) else $error("b8");
  a_link_rise: assert property ($rose(unreliable_link_flag)
    && !reg_wr && !m_q[16] |=> internal_error_report[16]) else $error("b16");
  a_mask_hide: assert property (!reg_wr
    |=> !(internal_error_report & m_q)) else $error("mask");
  a_report_hold: assert property (!reg_wr && !$past(reg_wr)
    |=> !($past(internal_error_report) & ~internal_error_report))
    else $error("lost");
  a_rsv_zero: assert property (reg_rd
    |=> reg_rdata[31:19] == 13'h0) else $error("rsv");
  a_mask_read: assert property (reg_rd && reg_addr == 12'h488
    |=> reg_rdata == ($past(m_q) & 32'h0007_FFF7)) else $error("mread");
  a_status_read: assert property (reg_rd && reg_addr == 12'h484
    |=> !($past(internal_error_report) & ~reg_rdata)) else $error("sread");
  c_pend: cover property (internal_error_pending);
  c_rise: cover property ($rose(unreliable_link_flag));
  c_clr: cover property (reg_wr && reg_addr == 12'h484);
endmodule : ierr_properties

// ==== testbench/testbench.sv ====
// self-checking bench for the internal error status and mask bank
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
  logic [11:0] reg_addr = '0;
  logic [10:0] v = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, m, exp_q[$];
  int error_cnt = 0, n_compared = 0, seed = 32'hA20F, i;
  always #4 clk_sys = ~clk_sys;
  internal_error_status_mask u_dut (.clk_sys, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ingress_data_double_err(v[0]), .ingress_ctrl_single_err(v[1]),
    .ingress_ctrl_double_err(v[2]), .egress_data_single_err(v[3]),
    .egress_data_double_err(v[4]), .egress_ctrl_single_err(v[5]),
    .egress_ctrl_double_err(v[6]), .datapath_parity_err(v[7]),
    .unreliable_link_flag(v[8]), .replay_ctrl_single_err(v[9]),
    .replay_ctrl_double_err(v[10]), .internal_error_report(),
    .internal_error_pending());
  task automatic chk(logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR reg_rdata exp %h seen %h", e, s);
    end
  endtask : chk
  // one bus cycle; a read queues d as its expected data
  task automatic acc(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk_sys);
    {reg_wr, reg_rd} <= 2'h0;
  endtask : acc
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d)
      chk(reg_rdata, exp_q.pop_front());
  end
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    acc(1'h0, 12'h484, 32'h0);
    for (i = 0; i < 11; i++) begin
      @(posedge clk_sys);
      v <= 11'h1 << i;
    end
    @(posedge clk_sys);
    v <= 11'h0;
    acc(1'h0, 12'h484, 32'h7FF00);
    m = $random(seed);
    acc(1'h1, 12'h488, m);
    acc(1'h0, 12'h488, m & 32'h7FFF7);
    acc(1'h0, 12'h48C, 32'h7FF00 & ~m);
    acc(1'h0, 12'h484, 32'h7FF00);
    m = $random(seed);
    acc(1'h1, 12'h484, m);
    acc(1'h0, 12'h484, 32'h7FF00 & ~m);
    acc(1'h1, 12'h490, m);
    acc(1'h0, 12'h490, 32'h0);
    // event held high through a clear, link flag held high
    @(posedge clk_sys);
    v <= 11'h101;
    acc(1'h1, 12'h484, 32'h7FF00);
    v <= 11'h100;
    acc(1'h0, 12'h484, 32'h100);
    v <= 11'h0;
    // reset in mid-run clears mask and status
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    acc(1'h0, 12'h488, 32'h0);
    acc(1'h0, 12'h484, 32'h0);
    repeat (2) @(posedge clk_sys);
    end_of_test();
  end
  initial begin
    #5000;
    error_cnt++;
    end_of_test();
  end
endmodule : testbench
bind internal_error_status_mask ierr_properties u_chk (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .ingress_data_double_err(ingress_data_double_err),
  .unreliable_link_flag(unreliable_link_flag),
  .internal_error_report(internal_error_report),
  .internal_error_pending(internal_error_pending)
);
